// [hw/hostport_pkg.sv]
// Purpose: Shared constants and types of the host port register file.
// Assumes: One 125 MHz clock, synchronous active-high reset.
// Notes:   Offsets are byte locations in the 256-entry register file.
package hostport_pkg;

  // ----------------------------------------------------------------------
  // Register file geometry and offsets
  // ----------------------------------------------------------------------
  localparam int       REG_DEPTH         = 256;
  localparam logic [7:0] OFF_XFER_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PORT1       = 8'h01;
  localparam logic [7:0] OFF_PORT2       = 8'h02;
  localparam logic [7:0] OFF_PORT3       = 8'h03;
  localparam logic [7:0] OFF_LIMIT       = 8'h04;
  localparam logic [7:0] OFF_INDIRECT    = 8'h05;
  localparam logic [7:0] OFF_GP_FIRST    = 8'h06;
  localparam logic [7:0] OFF_GP_LAST     = 8'hee;
  localparam logic [7:0] OFF_HOST_VEC    = 8'hf0;
  localparam logic [7:0] OFF_TMR         = 8'hf1;
  localparam logic [7:0] OFF_CNT1        = 8'hf2;
  localparam logic [7:0] OFF_PRESCALER_ONE        = 8'hf3;
  localparam logic [7:0] OFF_CNT0        = 8'hf4;
  localparam logic [7:0] OFF_PRESCALER_ZERO        = 8'hf5;
  localparam logic [7:0] OFF_P2DIR       = 8'hf6;
  localparam logic [7:0] OFF_P3CFG       = 8'hf7;
  localparam logic [7:0] OFF_P1DIR       = 8'hf8;
  localparam logic [7:0] OFF_IPRIO       = 8'hf9;
  localparam logic [7:0] OFF_IPEND       = 8'hfa;
  localparam logic [7:0] OFF_IMASK       = 8'hfb;
  localparam logic [7:0] OFF_FLAGS       = 8'hfc;
  localparam logic [7:0] OFF_RP          = 8'hfd;
  localparam logic [7:0] OFF_HOST_IC     = 8'hfe;
  localparam logic [7:0] OFF_SP          = 8'hff;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TMR_EN0_BIT       = 1;
  localparam int TMR_EN1_BIT       = 3;
  localparam int PRE_MODULO_BIT    = 0;
  localparam int P3CFG_P1_OD_BIT   = 3;
  localparam int P3CFG_P2_OD_BIT   = 4;
  localparam int IMASK_GLOBAL_BIT  = 7;
  localparam int IRQ_T0_BIT        = 4;
  localparam int IRQ_T1_BIT        = 5;

  // ----------------------------------------------------------------------
  // Program address space
  // ----------------------------------------------------------------------
  localparam logic [11:0] ROM_LAST       = 12'h7ff;
  localparam logic [11:0] VECTOR_END     = 12'h00c;
  localparam logic [11:0] BOOT_ROM_FIRST = 12'h00c;
  localparam logic [11:0] BOOT_ROM_LAST  = 12'h02f;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_KHZ       = 125000;
  localparam int CTRL_CLK_MAX_KHZ  = 4000;
  // Least period: round up so the core rate never passes its maximum
  localparam int CTRL_TICK_CYCLES  =
    (SYS_CLK_KHZ + CTRL_CLK_MAX_KHZ - 1) / CTRL_CLK_MAX_KHZ;
  localparam logic [5:0] CTRL_TICK_LAST = 6'(CTRL_TICK_CYCLES - 1);
  localparam logic [1:0] FIXED_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_XFER = 2'b10,
    H_DONE = 2'b11
  } host_state_t;

endpackage

// [hw/slave_controller_host_port_regfile.sv]
// Purpose: Host bus slave and 256-byte register file of a peripheral
//          controller, with ports, two timers and interrupt pending.
// Assumes: All bus pins are asynchronous to sys_clk.
// Notes:   Controller core rate is an enable pulse from sys_clk.
`timescale 1ns/1ps

module slave_controller_host_port_regfile #(
  parameter bit EXTENDED    = 1'b0,
  parameter bit RAM_VARIANT = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        address_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_write,
  input  wire logic [7:0]  muxed_bus_lines_in,
  output logic      [7:0]  muxed_bus_lines_out,
  output logic             muxed_bus_lines_oe_n,
  output logic             wait_out,
  output logic             wait_oe_n,
  input  wire logic        host_access_en,
  input  wire logic        prog_we,
  input  wire logic        prog_short,
  input  wire logic [7:0]  prog_addr,
  input  wire logic [7:0]  prog_wdata,
  output logic      [7:0]  prog_rdata,
  input  wire logic [11:0] fetch_addr,
  output logic             fetch_undefined,
  output logic             fetch_vector,
  output logic             fetch_boot_rom,
  input  wire logic [7:0]  port_one_in,
  output logic      [7:0]  port_one_out,
  output logic      [7:0]  port_one_oe_n,
  input  wire logic [7:0]  port_two_in,
  output logic      [7:0]  port_two_out,
  output logic      [7:0]  port_two_oe_n,
  input  wire logic [3:0]  port_three_in,
  output logic      [3:0]  port_three_out,
  output logic             irq_request,
  output logic             ctrl_reset
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic       as_m, as_s, as_d, ds_m, ds_s, cs_m, cs_s, rw_m, rw_s;
  logic [7:0] bus_m, bus_s;
  logic [7:0] p1_m, p1_s, p2_m, p2_s;
  logic [3:0] p3_m, p3_s, p3_d;

  // Bus pins pass two flops together, so address and strobes stay aligned
  always_ff @(posedge sys_clk) begin
    as_m  <= address_strobe_n;
    as_s  <= as_m;
    as_d  <= as_s;
    ds_m  <= data_strobe_n;
    ds_s  <= ds_m;
    cs_m  <= chip_select_n;
    cs_s  <= cs_m;
    rw_m  <= read_write;
    rw_s  <= rw_m;
    bus_m <= muxed_bus_lines_in;
    bus_s <= bus_m;
    p1_m  <= port_one_in;
    p1_s  <= p1_m;
    p2_m  <= port_two_in;
    p2_s  <= p2_m;
    p3_m  <= port_three_in;
    p3_s  <= p3_m;
    p3_d  <= p3_s;
  end

  logic as_rise;
  assign as_rise = as_s & ~as_d;

  // ----------------------------------------------------------------------
  // Strobe-combination reset
  // ----------------------------------------------------------------------
  logic host_reset_r, host_reset_nxt, core_rst;

  always_comb begin
    host_reset_nxt = host_reset_r;
    if (~as_s & ~ds_s)
      host_reset_nxt = 1'b1;
    else if (ds_s)
      host_reset_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      host_reset_r <= 1'b0;
    else
      host_reset_r <= host_reset_nxt;
  end

  assign core_rst = rst | host_reset_r;

  // ----------------------------------------------------------------------
  // Register file storage
  // ----------------------------------------------------------------------
  localparam int REG_DEPTH = hostport_pkg::REG_DEPTH;
  logic [7:0] regs [REG_DEPTH];
  logic [7:0] rp, tmr, p1dir, p2dir, p3cfg, imask, ipend;

  assign rp    = regs[hostport_pkg::OFF_RP];
  assign tmr   = regs[hostport_pkg::OFF_TMR];
  assign p1dir = regs[hostport_pkg::OFF_P1DIR];
  assign p2dir = regs[hostport_pkg::OFF_P2DIR];
  assign p3cfg = regs[hostport_pkg::OFF_P3CFG];
  assign imask = regs[hostport_pkg::OFF_IMASK];
  assign ipend = regs[hostport_pkg::OFF_IPEND];

  // Short format: pointer supplies the group, designator the register
  logic [7:0] prog_eff;
  assign prog_eff = prog_short ? {rp[7:4], prog_addr[3:0]}
                               : prog_addr;

  // Port locations read the pin for input bits, the latch for outputs
  function automatic logic [7:0] read_loc(input logic [7:0] a);
    logic [7:0] v;
    v = regs[a];
    unique case (a)
      hostport_pkg::OFF_PORT1: v = (p1_s & p1dir) | (v & ~p1dir);
      hostport_pkg::OFF_PORT2: v = (p2_s & p2dir) | (v & ~p2dir);
      hostport_pkg::OFF_PORT3: v = {v[7:4], p3_s};
      default:                 v = regs[a];
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Host transaction sequencer
  // ----------------------------------------------------------------------
  hostport_pkg::host_state_t hstate_r, hstate_nxt;
  logic [7:0] haddr_r, haddr_nxt, hdata_r, hdata_nxt;
  logic       hrw_r, hrw_nxt;
  logic       h_direct, h_indirect, h_go;
  logic [7:0] h_loc;

  // Only the eighteen control locations are direct; the rest go through
  // the indirect window addressed by the transfer control register
  assign h_direct   = (haddr_r == hostport_pkg::OFF_XFER_CTRL) ||
                      (haddr_r == hostport_pkg::OFF_LIMIT) ||
                      (haddr_r >= hostport_pkg::OFF_HOST_VEC);
  assign h_indirect = (haddr_r == hostport_pkg::OFF_INDIRECT);
  assign h_loc      = h_indirect ? regs[hostport_pkg::OFF_XFER_CTRL]
                                 : haddr_r;
  // A program write owns the file this cycle; the host retries next
  assign h_go = (hstate_r == hostport_pkg::H_XFER) & host_access_en &
                ~prog_we;

  always_comb begin
    hstate_nxt = hstate_r;
    haddr_nxt  = haddr_r;
    hdata_nxt  = hdata_r;
    hrw_nxt    = hrw_r;
    if (as_rise) begin
      // Address phase of the shared lines, taken at the strobe rise
      haddr_nxt = bus_s;
      hrw_nxt   = rw_s;
      hstate_nxt = cs_s ? hostport_pkg::H_IDLE
                        : hostport_pkg::H_ADDR;
    end else begin
      unique case (hstate_r)
        hostport_pkg::H_IDLE: hstate_nxt = hostport_pkg::H_IDLE;
        hostport_pkg::H_ADDR: begin
          if (~ds_s) begin
            hdata_nxt  = bus_s;
            hstate_nxt = hostport_pkg::H_XFER;
          end
        end
        hostport_pkg::H_XFER: begin
          if (h_go) begin
            if (hrw_r)
              hdata_nxt = (h_direct | h_indirect) ? read_loc(h_loc)
                                                  : 8'h00;
            hstate_nxt = hostport_pkg::H_DONE;
          end
        end
        hostport_pkg::H_DONE: begin
          if (ds_s)
            hstate_nxt = hostport_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      hstate_r <= hostport_pkg::H_IDLE;
      haddr_r  <= 8'h00;
      hdata_r  <= 8'h00;
      hrw_r    <= 1'b0;
    end else begin
      hstate_r <= hstate_nxt;
      haddr_r  <= haddr_nxt;
      hdata_r  <= hdata_nxt;
      hrw_r    <= hrw_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  logic bus_oe_n_nxt, wait_oe_n_nxt;

  always_comb begin
    // Drive read data only while the data strobe is low
    bus_oe_n_nxt  = ~(hstate_nxt == hostport_pkg::H_DONE && hrw_nxt &&
                      ~ds_s);
    wait_oe_n_nxt = ~(hstate_nxt == hostport_pkg::H_ADDR ||
                      hstate_nxt == hostport_pkg::H_XFER);
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      muxed_bus_lines_out  <= 8'h00;
      muxed_bus_lines_oe_n <= 1'b1;
      wait_out             <= 1'b0;
      wait_oe_n            <= 1'b1;
      ctrl_reset           <= 1'b1;
    end else begin
      muxed_bus_lines_out  <= hdata_nxt;
      muxed_bus_lines_oe_n <= bus_oe_n_nxt;
      wait_out             <= 1'b0;
      wait_oe_n            <= wait_oe_n_nxt;
      ctrl_reset           <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Core rate enable and timers
  // ----------------------------------------------------------------------
  logic [5:0] ctick_r, ctick_nxt;
  logic [1:0] div4_r, div4_nxt;
  logic       core_en, tick4;

  assign core_en = (ctick_r == hostport_pkg::CTRL_TICK_LAST);
  assign tick4   = core_en & (div4_r == hostport_pkg::FIXED_DIV_LAST);

  always_comb begin
    ctick_nxt = core_en ? 6'h00 : ctick_r + 6'h01;
    div4_nxt  = core_en ? div4_r + 2'h1 : div4_r;
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      ctick_r <= 6'h00;
      div4_r  <= 2'h0;
    end else begin
      ctick_r <= ctick_nxt;
      div4_r  <= div4_nxt;
    end
  end

  logic [1:0] tmr_end;
  logic [7:0] cnt_off [2];
  logic [7:0] pre_off [2];
  assign cnt_off[0] = hostport_pkg::OFF_CNT0;
  assign cnt_off[1] = hostport_pkg::OFF_CNT1;
  assign pre_off[0] = hostport_pkg::OFF_PRESCALER_ZERO;
  assign pre_off[1] = hostport_pkg::OFF_PRESCALER_ONE;

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_timer
      logic [5:0] pre_r, pre_nxt;
      logic [7:0] cnt_r, cnt_nxt;
      logic       run_r, run_nxt, en, load, endc;
      assign en   = tmr[t ? hostport_pkg::TMR_EN1_BIT
                          : hostport_pkg::TMR_EN0_BIT];
      assign load = prog_we & (prog_eff == cnt_off[t]);
      assign endc = run_r & en & tick4 & (pre_r == 6'h01) &
                    (cnt_r == 8'h01);
      assign tmr_end[t] = endc;
      // Zero fields stand for the full ranges of 64 and 256
      always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (load) begin
          pre_nxt = regs[pre_off[t]][7:2];
          cnt_nxt = prog_wdata;
          run_nxt = 1'b1;
        end else if (run_r & en & tick4) begin
          pre_nxt = (pre_r == 6'h01) ? regs[pre_off[t]][7:2]
                                     : pre_r - 6'h01;
          if (pre_r == 6'h01) begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              cnt_nxt = regs[cnt_off[t]];
              run_nxt = regs[pre_off[t]][hostport_pkg::PRE_MODULO_BIT];
            end
          end
        end
      end
      always_ff @(posedge sys_clk) begin
        if (core_rst) begin
          pre_r <= 6'h00;
          cnt_r <= 8'h00;
          run_r <= 1'b0;
        end else begin
          pre_r <= pre_nxt;
          cnt_r <= cnt_nxt;
          run_r <= run_nxt;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt pending, ports and program address decode
  // ----------------------------------------------------------------------
  logic [7:0] irq_set, ipend_base, ipend_nxt;
  logic       h_wr;

  assign h_wr = h_go & ~hrw_r & (h_direct | h_indirect);

  always_comb begin
    irq_set = 8'h00;
    irq_set[0] = p3_d[2] & ~p3_s[2];
    irq_set[1] = p3_d[3] & ~p3_s[3];
    irq_set[2] = p3_d[1] & ~p3_s[1];
    irq_set[3] = p3_d[0] & ~p3_s[0];
    irq_set[hostport_pkg::IRQ_T0_BIT] = tmr_end[0];
    irq_set[hostport_pkg::IRQ_T1_BIT] = tmr_end[1];
    if (prog_we && prog_eff == hostport_pkg::OFF_IPEND)
      ipend_base = prog_wdata;
    else if (h_wr && h_loc == hostport_pkg::OFF_IPEND)
      ipend_base = hdata_r;
    else
      ipend_base = ipend;
    // A new request wins over a clear in the same cycle
    ipend_nxt = ipend_base | irq_set;
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      for (int i = 0; i < REG_DEPTH; i++)
        regs[i] <= hostport_pkg::REG_RESET;
    end else begin
      if (h_wr)
        regs[h_loc] <= hdata_r;
      if (h_go & h_indirect) begin
        regs[hostport_pkg::OFF_XFER_CTRL] <=
          regs[hostport_pkg::OFF_XFER_CTRL] + 8'h01;
        regs[hostport_pkg::OFF_LIMIT] <=
          regs[hostport_pkg::OFF_LIMIT] - 8'h01;
      end
      if (prog_we)
        regs[prog_eff] <= prog_wdata;
      regs[hostport_pkg::OFF_IPEND] <= ipend_nxt;
    end
  end

  logic [7:0] p1o_nxt, p1e_nxt, p2o_nxt, p2e_nxt;
  logic       od1, od2;
  assign od1 = p3cfg[hostport_pkg::P3CFG_P1_OD_BIT];
  assign od2 = p3cfg[hostport_pkg::P3CFG_P2_OD_BIT];

  // Open drain only pulls low; direction bit high means input
  always_comb begin
    p1o_nxt = od1 ? 8'h00 : regs[hostport_pkg::OFF_PORT1];
    p1e_nxt = od1 ? ~(~p1dir & ~regs[hostport_pkg::OFF_PORT1]) : p1dir;
    p2o_nxt = od2 ? 8'h00 : regs[hostport_pkg::OFF_PORT2];
    p2e_nxt = od2 ? ~(~p2dir & ~regs[hostport_pkg::OFF_PORT2]) : p2dir;
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      port_one_out    <= 8'h00;
      port_one_oe_n   <= 8'hff;
      port_two_out    <= 8'h00;
      port_two_oe_n   <= 8'hff;
      port_three_out  <= 4'h0;
      irq_request     <= 1'b0;
      prog_rdata      <= 8'h00;
      fetch_undefined <= 1'b0;
      fetch_vector    <= 1'b0;
      fetch_boot_rom  <= 1'b0;
    end else begin
      port_one_out    <= p1o_nxt;
      port_one_oe_n   <= p1e_nxt;
      port_two_out    <= p2o_nxt;
      port_two_oe_n   <= p2e_nxt;
      port_three_out  <= regs[hostport_pkg::OFF_PORT3][7:4];
      irq_request     <= imask[hostport_pkg::IMASK_GLOBAL_BIT] &
                         (|(ipend[5:0] & imask[5:0]));
      prog_rdata      <= read_loc(prog_eff);
      fetch_undefined <= ~EXTENDED &
                         (fetch_addr > hostport_pkg::ROM_LAST);
      fetch_vector    <= fetch_addr < hostport_pkg::VECTOR_END;
      fetch_boot_rom  <= RAM_VARIANT &
                         (fetch_addr >= hostport_pkg::BOOT_ROM_FIRST) &
                         (fetch_addr <= hostport_pkg::BOOT_ROM_LAST);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_selected;
    as_rise && !cs_s;
  endsequence

  sequence s_xfer_go;
    hstate_r == hostport_pkg::H_XFER && host_access_en && !prog_we;
  endsequence

  a_wait_on_select:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      s_selected |=> !wait_oe_n && hstate_r == hostport_pkg::H_ADDR)
    else $error("wait not asserted after selected address strobe");

  a_deselect_idle:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      as_rise && cs_s |=> hstate_r == hostport_pkg::H_IDLE && wait_oe_n)
    else $error("unselected transaction was taken");

  a_strobe_reset:
    assert property (@(posedge sys_clk) disable iff (rst)
      !as_s && !ds_s |-> ##2 ctrl_reset)
    else $error("strobe combination did not reset");

  a_drive_in_ds:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      !muxed_bus_lines_oe_n |-> $past(!ds_s) && hrw_r)
    else $error("bus driven outside data strobe");

  a_wait_release:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      s_xfer_go ##1 !as_rise[*1] |-> wait_oe_n)
    else $error("wait not released after access");

  a_access_gate:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      hstate_r == hostport_pkg::H_XFER && !host_access_en && !as_rise
      |=> hstate_r == hostport_pkg::H_XFER && !wait_oe_n)
    else $error("host access completed while gated off");

  a_addr_hold:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      hstate_r != hostport_pkg::H_IDLE && !as_rise |=> $stable(haddr_r))
    else $error("latched address changed within transaction");

  a_irq_falling:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      p3_d[3] && !p3_s[3] |=> ipend[1])
    else $error("falling input did not raise request");

  a_timer_irq:
    assert property (@(posedge sys_clk) disable iff (core_rst)
      tmr_end[0] |=> ipend[hostport_pkg::IRQ_T0_BIT])
    else $error("timer end did not raise request");

endmodule

// [sim/master_bus_model.sv]
// Purpose: Master CPU model on the multiplexed strobe bus.
// Assumes: Every pin changes at the falling edge of sys_clk.
// Notes:   Lines carry no pull, so released lines show the inverse byte.
`timescale 1ns/1ps
module master_bus_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe_n,
  input  wire logic       wait_oe_n,
  output logic            as_n,
  output logic            ds_n,
  output logic            cs_n,
  output logic            rw,
  output logic [7:0]      bus_in
);
  logic [7:0] drv;
  logic       rel;

  assign bus_in = !rel ? drv : (bus_oe_n === 1'b0 ? bus_out : ~drv);

  initial begin
    as_n = 1'b1;
    ds_n = 1'b1;
    cs_n = 1'b1;
    rw   = 1'b1;
    drv  = 8'h00;
    rel  = 1'b0;
  end

  task automatic xfer(input logic rd, input logic sel,
                      input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic waited,
                      output logic hung);
    int n;
    @(negedge sys_clk);
    cs_n = !sel;
    rw   = rd;
    drv  = a;
    as_n = 1'b0;
    @(negedge sys_clk);
    as_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    waited = !wait_oe_n;
    drv  = d;
    rel  = rd;
    ds_n = 1'b0;
    n = 0;
    while (wait_oe_n !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    hung = (n == 400);
    @(negedge sys_clk);
    q    = bus_in;
    ds_n = 1'b1;
    cs_n = 1'b1;
    rel  = 1'b0;
  endtask

  // Data strobe alone keeps the reset held once both went low
  task automatic strobe_hold();
    @(negedge sys_clk);
    as_n = 1'b0;
    ds_n = 1'b0;
    @(negedge sys_clk);
    as_n = 1'b1;
  endtask

  task automatic strobe_end();
    @(negedge sys_clk);
    ds_n = 1'b1;
  endtask
endmodule

// [sim/slave_controller_host_port_regfile_tb_top.sv]
// Purpose: Self-checking bench of the host port register file.
// Assumes: Default parameters; inputs change at the falling edge.
// Notes:   Host traffic goes through the master model's tasks.
`timescale 1ns/1ps
module slave_controller_host_port_regfile_tb_top;
  logic        sys_clk, rst, as_n, ds_n, cs_n, rw, host_en, pwe, pshort;
  logic [7:0]  bin, bout, paddr, pwd, prd, p1o, p1oe, q, p2o, p2oe;
  logic        bus_oe_n, wait_oe_n, fu, fv, crst, w, h, fbr, wo, irq;
  logic [3:0]  p3i, p3o;
  logic [11:0] faddr;
  int          fails, total_checks;
  logic [7:0]  regs [13] = '{8'h00, 8'h04, 8'hf0, 8'hf3, 8'hf5, 8'hf6,
                             8'hf7, 8'hf8, 8'hf9, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  logic [13:0] ftab [4] = '{{12'h7ff, 2'b00}, {12'h800, 2'b10},
                            {12'h00b, 2'b01}, {12'h00c, 2'b00}};

  master_bus_model m (.sys_clk(sys_clk), .bus_out(bout), .bus_oe_n(bus_oe_n),
    .wait_oe_n(wait_oe_n), .as_n(as_n), .ds_n(ds_n), .cs_n(cs_n), .rw(rw),
    .bus_in(bin));

  slave_controller_host_port_regfile dut (.sys_clk(sys_clk), .rst(rst),
    .address_strobe_n(as_n), .data_strobe_n(ds_n), .chip_select_n(cs_n),
    .read_write(rw), .muxed_bus_lines_in(bin), .muxed_bus_lines_out(bout),
    .muxed_bus_lines_oe_n(bus_oe_n), .wait_out(wo), .wait_oe_n(wait_oe_n),
    .host_access_en(host_en), .prog_we(pwe), .prog_short(pshort),
    .prog_addr(paddr), .prog_wdata(pwd), .prog_rdata(prd),
    .fetch_addr(faddr), .fetch_undefined(fu), .fetch_vector(fv),
    .fetch_boot_rom(fbr), .port_one_in(8'h00), .port_one_out(p1o),
    .port_one_oe_n(p1oe), .port_two_in(8'h00), .port_two_out(p2o),
    .port_two_oe_n(p2oe), .port_three_in(p3i), .port_three_out(p3o),
    .irq_request(irq), .ctrl_reset(crst));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask

  task automatic test_done();
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic host(input logic rd, input logic [7:0] a,
                      input logic [7:0] d);
    m.xfer(rd, 1'b1, a, d, q, w, h);
    if (h) begin
      fails++;
      test_done();
    end
  endtask

  task automatic hrd(input logic [7:0] a, input logic [7:0] e);
    host(1'b1, a, 8'h00);
    chk("host read", q, e);
  endtask

  task automatic prg(input logic sh, input logic [7:0] a, input logic we,
                     input logic [7:0] d);
    @(negedge sys_clk);
    pshort = sh;
    paddr  = a;
    pwe    = we;
    pwd    = d;
    @(negedge sys_clk);
    pwe    = 1'b0;
    pshort = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    host_en = 1'b1;
    pwe = 1'b0;
    pshort = 1'b0;
    paddr = 8'h00;
    pwd = 8'h00;
    faddr = 12'h000;
    p3i = 4'h8;
    fails = 0;
    total_checks = 0;
    repeat (10) @(negedge sys_clk);
    chk("ctrl reset", {7'h00, crst}, 8'h01);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("idle outputs", {5'h00, wo, wait_oe_n, bus_oe_n}, 8'h03);
    foreach (regs[i]) begin
      host(1'b0, regs[i], 8'h5a ^ regs[i]);
      hrd(regs[i], 8'h5a ^ regs[i]);
    end
    m.xfer(1'b0, 1'b0, 8'hfc, 8'h11, q, w, h);
    chk("unselected wait", {7'h00, w}, 8'h00);
    hrd(8'hfc, 8'ha6);
    host(1'b0, 8'h01, 8'hff);
    hrd(8'h01, 8'h00);
    host_en = 1'b0;
    fork
      host(1'b0, 8'hfc, 8'h3c);
      begin
        repeat (40) @(negedge sys_clk);
        chk("gated wait", {7'h00, wait_oe_n}, 8'h00);
        host_en = 1'b1;
      end
    join
    hrd(8'hfc, 8'h3c);
    host(1'b0, 8'hfd, 8'h20);
    prg(1'b1, 8'h03, 1'b1, 8'h77);
    prg(1'b0, 8'h23, 1'b0, 8'h00);
    chk("short write", prd, 8'h77);
    hrd(8'h23, 8'h00);
    prg(1'b0, 8'hee, 1'b1, 8'hc3);
    prg(1'b0, 8'hee, 1'b0, 8'h00);
    chk("general reg", prd, 8'hc3);
    host(1'b0, 8'h00, 8'h30);
    host(1'b0, 8'h04, 8'h02);
    prg(1'b0, 8'h30, 1'b1, 8'h5a);
    hrd(8'h05, 8'h5a);
    hrd(8'h00, 8'h31);
    hrd(8'h04, 8'h01);
    prg(1'b0, 8'hf7, 1'b1, 8'h00);
    prg(1'b0, 8'hf8, 1'b1, 8'h00);
    prg(1'b0, 8'h03, 1'b1, 8'hc0);
    prg(1'b0, 8'h01, 1'b1, 8'ha5);
    @(negedge sys_clk);
    chk("port one out", p1o, 8'ha5);
    chk("port one oe", p1oe, 8'h00);
    chk("port two out", p2o, 8'h00);
    chk("port two oe", p2oe, 8'hac);
    chk("port three out", {4'h0, p3o}, 8'h0c);
    foreach (ftab[i]) begin
      faddr = ftab[i][13:2];
      repeat (2) @(negedge sys_clk);
      chk("fetch class", {5'h00, fbr, fu, fv},
          {6'h00, ftab[i][1:0]});
    end
    // Input line 3 falls; timer 0 makes one pass of one tick
    p3i = 4'h0;
    prg(1'b0, 8'hf1, 1'b1, 8'h02);
    prg(1'b0, 8'hf5, 1'b1, 8'h04);
    prg(1'b0, 8'hf4, 1'b1, 8'h01);
    prg(1'b0, 8'hfb, 1'b1, 8'h82);
    repeat (140) @(negedge sys_clk);
    prg(1'b0, 8'hfa, 1'b0, 8'h00);
    chk("pending", prd, 8'h12);
    chk("irq out", {7'h00, irq}, 8'h01);
    m.strobe_hold();
    repeat (8) @(negedge sys_clk);
    chk("strobe reset", {7'h00, crst}, 8'h01);
    m.strobe_end();
    repeat (4) @(negedge sys_clk);
    chk("reset end", {7'h00, crst}, 8'h00);
    hrd(8'hfc, 8'h00);
    test_done();
  end
endmodule
